// File: pkg/isbe_pkg.sv
// Constants and types shared by the slave error, boot error and event logic
package isbe_pkg;

    // Clock rate and default timeout periods
    localparam int CLK_MHZ         = 100;
    localparam int SCL_LOW_TMO_US  = 25;
    localparam int BYTE_TMO_US     = 100;
    localparam int XACT_TMO_US     = 1000;
    localparam int SCL_LOW_TMO_CYC = SCL_LOW_TMO_US * CLK_MHZ;
    localparam int BYTE_TMO_CYC    = BYTE_TMO_US * CLK_MHZ;
    localparam int XACT_TMO_CYC    = XACT_TMO_US * CLK_MHZ;
    localparam int TMO_CNT_W       = 20;

    // Event vector layout
    localparam int EVT_W      = 11;
    localparam int EV_SCLTO   = 0;
    localparam int EV_BYTTO   = 1;
    localparam int EV_TRTO    = 2;
    localparam int EV_COL     = 3;
    localparam int EV_WRDN    = 4;
    localparam int EV_RDDN    = 5;
    localparam int EV_DONE    = 6;
    localparam int EV_BL_BASE = 7;
    localparam int BL_EVT_W   = 4;

    // Boot event layout within the boot group
    localparam int BE_NOD = 0;
    localparam int BE_SZ  = 1;
    localparam int BE_TO  = 2;
    localparam int BE_ERR = 3;

    // Interrupt status layout
    localparam int STAT_W      = 5;
    localparam int ST_SLV_FAIL  = 0;
    localparam int ST_SLV_WRITE = 1;
    localparam int ST_SLV_READ  = 2;
    localparam int ST_SLV_OK    = 3;
    localparam int ST_BOOT_FAIL = 4;

    // Events that feed each status bit, status bit 4 first
    localparam logic [STAT_W-1:0][EVT_W-1:0] GRP_MAP = {
        11'h780, 11'h040, 11'h020, 11'h010, 11'h00F
    };

    // Boot loader limits
    localparam logic [2:0]  BL_MAX_TRIES  = 3'h6;
    localparam logic [15:0] BL_MAX_REGS_1B = 16'h00FF;
    localparam logic [15:0] BL_MAX_REGS_2B = 16'h1FFF;
    localparam logic [2:0]  CNT_PAD_FIRST = 3'h2;
    localparam logic [2:0]  CNT_PAD_LAST  = 3'h7;
    localparam logic [7:0]  CNT_PAD_BYTE  = 8'hFF;

    // Slave guard states
    typedef enum logic [1:0] {
        SL_IDLE = 2'b00,
        SL_XFER = 2'b01,
        SL_WAIT = 2'b10
    } isbe_sl_state_t;

endpackage

// File: verilog/isbe_boot_err.sv
// Boot loader error detection: retries, size, arbitration, timer and protocol faults
`timescale 1ns/1ps
`default_nettype none

module isbe_boot_err (
    // Clock and reset
    input  wire logic                          i_sys_clk,
    input  wire logic                          i_rst_n,
    // Loader progress
    input  wire logic                          i_load_start,
    input  wire logic                          i_try_done,
    input  wire logic                          i_try_acked,
    input  wire logic                          i_size_valid,
    input  wire logic                          i_two_byte_mode,
    input  wire logic [15:0]                   i_size,
    input  wire logic                          i_arb_lost,
    input  wire logic                          i_timer_expired,
    input  wire logic                          i_proto_err,
    input  wire logic                          i_cnt_valid,
    input  wire logic [2:0]                    i_cnt_idx,
    input  wire logic [7:0]                    i_cnt_byte,
    input  wire logic                          i_wr_valid,
    input  wire logic                          i_wr_addr_exists,
    // Results
    output logic                               o_retry,
    output logic                               o_abort,
    output logic                               o_wr_commit,
    output logic [isbe_pkg::BL_EVT_W-1:0]      o_evt
);

    typedef struct packed {
        logic                          active;
        logic [2:0]                    tries;
        logic                          retry;
        logic                          abort;
        logic                          commit;
        logic [isbe_pkg::BL_EVT_W-1:0] evt;
    } isbe_boot_state_t;

    isbe_boot_state_t r_ff;
    isbe_boot_state_t nxt_r;

    logic nack;
    logic size_bad;
    logic pad_bad;

    always_comb begin
        nxt_r        = r_ff;
        nxt_r.retry  = 1'b0;
        nxt_r.abort  = 1'b0;
        nxt_r.commit = 1'b0;
        nxt_r.evt    = '0;
        nack     = r_ff.active && i_try_done && !i_try_acked;
        size_bad = r_ff.active && i_size_valid &&
                   (i_two_byte_mode ? (i_size > isbe_pkg::BL_MAX_REGS_2B)
                                    : (i_size > isbe_pkg::BL_MAX_REGS_1B));
        pad_bad  = r_ff.active && i_cnt_valid && i_cnt_idx >= isbe_pkg::CNT_PAD_FIRST &&
                   i_cnt_idx <= isbe_pkg::CNT_PAD_LAST && i_cnt_byte != isbe_pkg::CNT_PAD_BYTE;
        if (i_load_start) begin
            nxt_r.active = 1'b1;
            nxt_r.tries  = '0;
        end else if (r_ff.active) begin
            if (i_try_done && i_try_acked) begin
                nxt_r.tries = '0;
            end
            if (nack) begin
                if (r_ff.tries == isbe_pkg::BL_MAX_TRIES - 3'h1) begin
                    nxt_r.evt[isbe_pkg::BE_NOD] = 1'b1;
                end else begin
                    nxt_r.tries = r_ff.tries + 3'h1;
                    nxt_r.retry = 1'b1;
                end
            end
            nxt_r.evt[isbe_pkg::BE_SZ]  = size_bad;
            nxt_r.evt[isbe_pkg::BE_TO]  = i_arb_lost || i_timer_expired;
            nxt_r.evt[isbe_pkg::BE_ERR] = i_proto_err || pad_bad;
            if (nxt_r.evt != '0) begin
                nxt_r.abort  = 1'b1;
                nxt_r.active = 1'b0;
            end
            // Missing target register: word dropped silently
            nxt_r.commit = i_wr_valid && i_wr_addr_exists && nxt_r.evt == '0;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            r_ff <= '0;
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign o_retry     = r_ff.retry;
    assign o_abort     = r_ff.abort;
    assign o_wr_commit = r_ff.commit;
    assign o_evt       = r_ff.evt;

    property p_no_device;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (nack && r_ff.tries == isbe_pkg::BL_MAX_TRIES - 3'h1 && !i_load_start)
        |=> o_abort && o_evt[isbe_pkg::BE_NOD] && !o_retry;
    endproperty
    a_no_device: assert property (p_no_device) else $error("no-device abort missing");

    property p_size;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (size_bad && !i_load_start) |=> o_abort && o_evt[isbe_pkg::BE_SZ] ##1 !o_abort;
    endproperty
    a_size: assert property (p_size) else $error("size abort missing");

    property p_discard;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_wr_valid && !i_wr_addr_exists) |=> !o_wr_commit;
    endproperty
    a_discard: assert property (p_discard) else $error("write to missing register kept");

    property p_timeout;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (r_ff.active && !i_load_start && (i_arb_lost || i_timer_expired))
        |=> o_abort && o_evt[isbe_pkg::BE_TO] ##1 !r_ff.active || $past(i_load_start);
    endproperty
    a_timeout: assert property (p_timeout) else $error("boot timeout abort missing");

    property p_proto;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (pad_bad && !i_load_start) |=> o_abort && o_evt[isbe_pkg::BE_ERR];
    endproperty
    a_proto: assert property (p_proto) else $error("boot protocol abort missing");

endmodule
`default_nettype wire

// File: verilog/isbe_slave_err_irq.sv
// Slave error guard, restricted register access and event/interrupt logic
`timescale 1ns/1ps
`default_nettype none

module isbe_slave_err_irq #(
    parameter int P_SCL_LOW_CYC = isbe_pkg::SCL_LOW_TMO_CYC,
    parameter int P_BYTE_CYC    = isbe_pkg::BYTE_TMO_CYC,
    parameter int P_XACT_CYC    = isbe_pkg::XACT_TMO_CYC
) (
    // Clock and reset
    input  wire logic                          i_sys_clk,
    input  wire logic                          i_rst_n,
    // Bus pins
    input  wire logic                          i_scl,
    output logic                               o_scl_o,
    output logic                               o_scl_oe,
    input  wire logic                          i_serial_data_line,
    output logic                               o_serial_data_line_o,
    output logic                               o_serial_data_line_oe,
    // Slave engine
    input  wire logic                          i_slv_active,
    input  wire logic                          i_slv_byte_start,
    input  wire logic                          i_slv_drive_phase,
    input  wire logic                          i_slv_sda_val,
    input  wire logic                          i_slv_scl_stretch,
    input  wire logic                          i_slv_xact_done,
    output logic                               o_slv_abort,
    // External register path
    input  wire logic                          i_reg_acc_en,
    input  wire logic                          i_ext_wr,
    input  wire logic [7:0]                    i_ext_wr_data,
    input  wire logic                          i_ext_rd,
    output logic [7:0]                         o_external_write_data_reg,
    output logic [7:0]                         o_external_read_data_reg,
    output logic                               o_int_wr_req,
    output logic                               o_int_rd_req,
    input  wire logic                          i_int_wr_done,
    input  wire logic                          i_int_rd_done,
    input  wire logic [7:0]                    i_int_rd_data,
    // Boot loader
    input  wire logic                          i_bl_load_start,
    input  wire logic                          i_bl_try_done,
    input  wire logic                          i_bl_try_acked,
    input  wire logic                          i_bl_size_valid,
    input  wire logic                          i_bl_two_byte_mode,
    input  wire logic [15:0]                   i_bl_size,
    input  wire logic                          i_bl_arb_lost,
    input  wire logic                          i_bl_timer_expired,
    input  wire logic                          i_bl_proto_err,
    input  wire logic                          i_bl_cnt_valid,
    input  wire logic [2:0]                    i_bl_cnt_idx,
    input  wire logic [7:0]                    i_bl_cnt_byte,
    input  wire logic                          i_bl_wr_valid,
    input  wire logic                          i_bl_wr_addr_exists,
    output logic                               o_bl_retry,
    output logic                               o_bl_abort,
    output logic                               o_bl_wr_commit,
    // Software status and interrupt
    input  wire logic                          i_stat_rd,
    input  wire logic [isbe_pkg::STAT_W-1:0]   i_stat_w1c,
    input  wire logic [isbe_pkg::STAT_W-1:0]   i_stat_w1s,
    input  wire logic [isbe_pkg::STAT_W-1:0]   i_int_en,
    input  wire logic [isbe_pkg::EVT_W-1:0]    i_evt_en,
    output logic [isbe_pkg::STAT_W-1:0]        o_int_status,
    output logic [isbe_pkg::EVT_W-1:0]         o_evt_state,
    output logic                               o_irq
);

    localparam int CW = isbe_pkg::TMO_CNT_W;

    typedef struct packed {
        isbe_pkg::isbe_sl_state_t   st;
        logic [1:0]                 scl_sy;
        logic [1:0]                 sda_sy;
        logic                       scl_prev;
        logic [CW-1:0]              low_cnt;
        logic [CW-1:0]              byte_cnt;
        logic [CW-1:0]              xact_cnt;
        logic                       sda_low;
        logic                       scl_low;
        logic                       abort;
        logic [7:0]                 wr_data;
        logic [7:0]                 rd_data;
        logic                       int_wr;
        logic                       int_rd;
        logic [isbe_pkg::EVT_W-1:0] new_evt;
        logic [isbe_pkg::EVT_W-1:0] snap;
    } isbe_main_state_t;

    isbe_main_state_t r_ff;
    isbe_main_state_t nxt_r;

    logic [isbe_pkg::BL_EVT_W-1:0] bl_evt;
    logic [isbe_pkg::EVT_W-1:0]    hw_evt;
    logic [isbe_pkg::EVT_W-1:0]    evt_state;
    logic                          xfer;
    logic                          scl_rise;
    logic                          t_low;
    logic                          t_byte;
    logic                          t_xact;
    logic                          col;
    logic                          fail;

    // Events belonging to a set of status bits
    function automatic logic [isbe_pkg::EVT_W-1:0] grp_mask(
        input logic [isbe_pkg::STAT_W-1:0] bits
    );
        logic [isbe_pkg::EVT_W-1:0] m;
        m = '0;
        for (int i = 0; i < isbe_pkg::STAT_W; i++) begin
            if (bits[i]) begin
                m = m | isbe_pkg::GRP_MAP[i];
            end
        end
        return m;
    endfunction

    isbe_boot_err u_boot (
        .i_sys_clk        (i_sys_clk),
        .i_rst_n          (i_rst_n),
        .i_load_start     (i_bl_load_start),
        .i_try_done       (i_bl_try_done),
        .i_try_acked      (i_bl_try_acked),
        .i_size_valid     (i_bl_size_valid),
        .i_two_byte_mode  (i_bl_two_byte_mode),
        .i_size           (i_bl_size),
        .i_arb_lost       (i_bl_arb_lost),
        .i_timer_expired  (i_bl_timer_expired),
        .i_proto_err      (i_bl_proto_err),
        .i_cnt_valid      (i_bl_cnt_valid),
        .i_cnt_idx        (i_bl_cnt_idx),
        .i_cnt_byte       (i_bl_cnt_byte),
        .i_wr_valid       (i_bl_wr_valid),
        .i_wr_addr_exists (i_bl_wr_addr_exists),
        .o_retry          (o_bl_retry),
        .o_abort          (o_bl_abort),
        .o_wr_commit      (o_bl_wr_commit),
        .o_evt            (bl_evt)
    );

    always_comb begin
        nxt_r        = r_ff;
        nxt_r.scl_sy = {r_ff.scl_sy[0], i_scl};
        nxt_r.sda_sy = {r_ff.sda_sy[0], i_serial_data_line};
        nxt_r.scl_prev = r_ff.scl_sy[1];
        nxt_r.abort  = 1'b0;
        nxt_r.int_wr = 1'b0;
        nxt_r.int_rd = 1'b0;
        xfer     = r_ff.st == isbe_pkg::SL_XFER;
        scl_rise = r_ff.scl_sy[1] && !r_ff.scl_prev;
        t_low    = xfer && !r_ff.scl_sy[1] && r_ff.low_cnt >= CW'(P_SCL_LOW_CYC);
        t_byte   = xfer && r_ff.byte_cnt >= CW'(P_BYTE_CYC);
        t_xact   = xfer && r_ff.xact_cnt >= CW'(P_XACT_CYC);
        col      = xfer && scl_rise && i_slv_drive_phase && i_slv_sda_val &&
                   !r_ff.sda_sy[1];
        fail     = t_low || t_byte || t_xact || col;
        // Slave guard
        nxt_r.low_cnt  = '0;
        nxt_r.byte_cnt = '0;
        nxt_r.xact_cnt = '0;
        nxt_r.sda_low  = 1'b0;
        nxt_r.scl_low  = 1'b0;
        case (r_ff.st)
            isbe_pkg::SL_IDLE: begin
                if (i_slv_active) begin
                    nxt_r.st = isbe_pkg::SL_XFER;
                end
            end
            isbe_pkg::SL_XFER: begin
                if (fail) begin
                    nxt_r.st    = isbe_pkg::SL_WAIT;
                    nxt_r.abort = 1'b1;
                end else if (!i_slv_active) begin
                    nxt_r.st = isbe_pkg::SL_IDLE;
                end else begin
                    nxt_r.low_cnt  = r_ff.scl_sy[1] ? '0 : r_ff.low_cnt + CW'(1);
                    nxt_r.byte_cnt = i_slv_byte_start ? '0 : r_ff.byte_cnt + CW'(1);
                    nxt_r.xact_cnt = r_ff.xact_cnt + CW'(1);
                    nxt_r.sda_low  = i_slv_drive_phase && !i_slv_sda_val;
                    nxt_r.scl_low  = i_slv_scl_stretch;
                end
            end
            isbe_pkg::SL_WAIT: begin
                if (!i_slv_active) begin
                    nxt_r.st = isbe_pkg::SL_IDLE;
                end
            end
            default: begin
                nxt_r.st = isbe_pkg::SL_IDLE;
            end
        endcase
        // External register path
        if (i_ext_wr) begin
            nxt_r.wr_data = i_ext_wr_data;
            nxt_r.int_wr  = i_reg_acc_en;
        end
        nxt_r.int_rd = i_ext_rd && i_reg_acc_en;
        if (i_int_rd_done) begin
            nxt_r.rd_data = i_int_rd_data;
        end
        // Events
        hw_evt = '0;
        hw_evt[isbe_pkg::EV_SCLTO] = t_low;
        hw_evt[isbe_pkg::EV_BYTTO] = t_byte;
        hw_evt[isbe_pkg::EV_TRTO]  = t_xact;
        hw_evt[isbe_pkg::EV_COL]   = col;
        hw_evt[isbe_pkg::EV_WRDN]  = i_int_wr_done;
        hw_evt[isbe_pkg::EV_RDDN]  = i_int_rd_done;
        hw_evt[isbe_pkg::EV_DONE]  = i_slv_xact_done;
        hw_evt[isbe_pkg::EV_BL_BASE +: isbe_pkg::BL_EVT_W] = bl_evt;
        // Snapshot on read, clear acts on snapshot only, new events survive
        nxt_r.snap = (i_stat_rd ? (r_ff.snap | r_ff.new_evt) : r_ff.snap) &
                     ~(grp_mask(i_stat_w1c) & i_evt_en);
        nxt_r.new_evt = (i_stat_rd ? '0 : r_ff.new_evt) | hw_evt |
                        grp_mask(i_stat_w1s);
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            r_ff        <= '0;
            r_ff.scl_sy <= 2'h3;
            r_ff.sda_sy <= 2'h3;
            r_ff.scl_prev <= 1'b1;
        end else begin
            r_ff <= nxt_r;
        end
    end

    always_comb begin
        evt_state = (r_ff.new_evt | r_ff.snap) & i_evt_en;
        for (int i = 0; i < isbe_pkg::STAT_W; i++) begin
            o_int_status[i] = |(evt_state & isbe_pkg::GRP_MAP[i]);
        end
    end

    assign o_irq                     = |(o_int_status & i_int_en);
    assign o_evt_state               = r_ff.new_evt | r_ff.snap;
    assign o_scl_o                   = 1'b0;
    assign o_scl_oe                  = r_ff.scl_low;
    assign o_serial_data_line_o      = 1'b0;
    assign o_serial_data_line_oe     = r_ff.sda_low;
    assign o_slv_abort               = r_ff.abort;
    assign o_external_write_data_reg = r_ff.wr_data;
    assign o_external_read_data_reg  = r_ff.rd_data;
    assign o_int_wr_req              = r_ff.int_wr;
    assign o_int_rd_req              = r_ff.int_rd;

    property p_tmo_release;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (t_low || t_byte || t_xact) |=> r_ff.st == isbe_pkg::SL_WAIT && !o_scl_oe &&
        !o_serial_data_line_oe && o_slv_abort && (r_ff.new_evt[2:0] != 3'h0);
    endproperty
    a_tmo_release: assert property (p_tmo_release) else $error("timeout not handled");

    property p_col_release;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        col |=> r_ff.st == isbe_pkg::SL_WAIT && !o_serial_data_line_oe &&
        r_ff.new_evt[isbe_pkg::EV_COL];
    endproperty
    a_col_release: assert property (p_col_release) else $error("collision not handled");

    property p_disabled_acc;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (!i_reg_acc_en && i_ext_wr && !i_ext_rd) |=> !o_int_wr_req && !o_int_rd_req &&
        o_external_write_data_reg == $past(i_ext_wr_data);
    endproperty
    a_disabled_acc: assert property (p_disabled_acc) else $error("disabled access leaked");

    property p_irq_level;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        o_irq == ((evt_state & grp_mask(i_int_en)) != '0);
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong");

    property p_w1s;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        i_stat_w1s[isbe_pkg::ST_SLV_FAIL] |=>
        r_ff.new_evt[3:0] == 4'hF;
    endproperty
    a_w1s: assert property (p_w1s) else $error("set register had no effect");

    property p_snap_needs_read;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        !i_stat_rd |=> (r_ff.snap & ~$past(r_ff.snap)) == '0;
    endproperty
    a_snap_needs_read: assert property (p_snap_needs_read) else $error("snapshot grew");

    property p_new_kept;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_stat_w1c != '0 && !i_stat_rd) |=> (r_ff.new_evt & $past(r_ff.new_evt)) ==
        $past(r_ff.new_evt);
    endproperty
    a_new_kept: assert property (p_new_kept) else $error("new event lost on clear");

    property p_snapshot;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_stat_rd && i_stat_w1c == '0) |=> r_ff.snap == ($past(r_ff.snap) |
        $past(r_ff.new_evt)) && (r_ff.new_evt & ~$past(hw_evt)) == '0 || $past(i_stat_w1s) != '0;
    endproperty
    a_snapshot: assert property (p_snapshot) else $error("snapshot merge wrong");

endmodule
`default_nettype wire

// File: bench/isbe_bus_peer.sv
// Far-side bus party: pull-ups, link clock within frames, data pull-down
`timescale 1ns/1ps
`default_nettype none
module isbe_bus_peer (
    input  wire logic i_run,
    input  wire logic i_hold_low,
    input  wire logic i_scl_oe,
    input  wire logic i_sda_oe,
    output logic      o_scl,
    output logic      o_sda
);
    logic clk_q = 1'b1;
    initial begin
        #3;
        forever #40 clk_q = i_run ? ~clk_q : 1'b1;
    end
    assign o_scl = clk_q & ~i_scl_oe;
    assign o_sda = ~i_hold_low & ~i_sda_oe;
endmodule
`default_nettype wire

// File: bench/tb_top.sv
// Self-checking bench for the slave error, boot error and interrupt logic
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    bit i_sys_clk, i_rst_n, i_slv_active, i_slv_byte_start, i_slv_drive_phase, i_slv_sda_val;
    bit i_slv_scl_stretch, i_slv_xact_done, i_reg_acc_en, i_ext_wr, i_ext_rd, i_int_wr_done;
    bit i_int_rd_done, i_bl_load_start, i_bl_try_done, i_bl_try_acked, i_bl_two_byte_mode;
    bit i_bl_wr_valid, i_bl_wr_addr_exists, i_stat_rd, run, hold_low;
    bit i_bl_arb_lost, i_bl_timer_expired, i_bl_proto_err, i_bl_size_valid, i_bl_cnt_valid;
    bit [7:0] i_ext_wr_data, i_int_rd_data, i_bl_cnt_byte;
    bit [15:0] i_bl_size;
    bit [2:0] i_bl_cnt_idx;
    bit [4:0] i_stat_w1c, i_stat_w1s, i_int_en, sel;
    bit [10:0] i_evt_en;
    logic i_scl, i_serial_data_line, o_scl_o, o_scl_oe, o_serial_data_line_o, o_slv_abort;
    logic o_serial_data_line_oe, o_int_wr_req, o_int_rd_req, o_bl_retry, o_bl_abort, o_irq;
    logic o_bl_wr_commit;
    logic [7:0] o_external_write_data_reg, o_external_read_data_reg;
    logic [4:0] o_int_status;
    logic [10:0] o_evt_state;
    logic [4:0] rows [5] = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h01};
    int ev [5] = '{9, 9, 10, 8, 10};
    int n_fail, samples_checked;
    assign {i_bl_arb_lost, i_bl_timer_expired, i_bl_proto_err} = sel[4:2];
    assign {i_bl_size_valid, i_bl_cnt_valid} = sel[1:0];
    isbe_slave_err_irq #(.P_SCL_LOW_CYC(20), .P_BYTE_CYC(40), .P_XACT_CYC(80))
        u_isbe_slave_err_irq (.*);
    isbe_bus_peer u_isbe_bus_peer (.i_run(run), .i_hold_low(hold_low), .i_scl_oe(o_scl_oe),
        .i_sda_oe(o_serial_data_line_oe), .o_scl(i_scl), .o_sda(i_serial_data_line));
    always #5 i_sys_clk = ~i_sys_clk;
    task automatic tick;
        @(negedge i_sys_clk);
    endtask
    task automatic pulse(ref bit s);
        s = 1'b1;
        tick;
        s = 1'b0;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] act);
        samples_checked++;
        if (act !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, act);
        end
    endtask
    task automatic give_verdict;
        $display("comparisons %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic clr(input string nm);
        pulse(i_stat_rd);
        i_stat_w1c = 5'h1F;
        tick;
        i_stat_w1c = 5'h00;
        tick;
        chk("status after clear", 0, {o_irq, o_int_status});
        $display("test %s done", nm);
    endtask
    task automatic wait_abort;
        int k;
        for (k = 0; k < 100 && o_slv_abort !== 1'b1; k++) tick;
        if (k == 100) begin
            n_fail++;
            give_verdict;
        end
        chk("line drive", 0, {o_scl_oe, o_serial_data_line_oe});
    endtask
    initial begin
        i_int_en = 5'h1F;
        i_evt_en = 11'h7FF;
        i_bl_size = 16'h0100;
        i_bl_cnt_idx = 3'h3;
        repeat (2) tick;
        i_rst_n = 1'b1;
        tick;
        chk("reset state", 0, {o_irq, o_int_status, o_evt_state});
        foreach (rows[r]) begin
            pulse(i_bl_load_start);
            sel = rows[r];
            tick;
            sel = 5'h00;
            chk("boot abort", 1, o_bl_abort);
            repeat (2) tick;
            chk("boot event", 1, o_evt_state[ev[r]]);
            chk("boot status", 6'h30, {o_irq, o_int_status});
            clr("boot abort row");
        end
        pulse(i_bl_load_start);
        for (int t = 1; t <= 6; t++) begin
            pulse(i_bl_try_done);
            chk("retry", t < 6, o_bl_retry);
            chk("no device abort", t == 6, o_bl_abort);
            tick;
        end
        tick;
        chk("no device event", 1, o_evt_state[7]);
        clr("retries");
        pulse(i_bl_load_start);
        pulse(i_bl_wr_valid);
        chk("discarded word", 0, o_bl_wr_commit);
        i_ext_wr_data = 8'hA5;
        pulse(i_ext_wr);
        chk("write data", 8'hA5, o_external_write_data_reg);
        chk("write request", 0, o_int_wr_req);
        pulse(i_ext_rd);
        chk("internal access", 0, {o_int_wr_req, o_int_rd_req, o_external_read_data_reg});
        repeat (2) tick;
        chk("quiet events", 0, o_evt_state);
        i_reg_acc_en = 1'b1;
        pulse(i_ext_wr);
        chk("enabled write request", 1, o_int_wr_req);
        pulse(i_ext_rd);
        chk("enabled read request", 1, o_int_rd_req);
        i_int_rd_data = 8'h3C;
        pulse(i_int_rd_done);
        chk("read data", 8'h3C, o_external_read_data_reg);
        pulse(i_int_wr_done);
        chk("done status", 6'h26, {o_irq, o_int_status});
        i_reg_acc_en = 1'b0;
        clr("enabled access");
        i_slv_active = 1'b1;
        i_slv_scl_stretch = 1'b1;
        wait_abort;
        chk("clock low event", 1, o_evt_state[0]);
        {i_slv_active, i_slv_scl_stretch} = 2'h0;
        clr("clock low timeout");
        {run, hold_low, i_slv_active, i_slv_drive_phase, i_slv_sda_val} = 5'h1F;
        wait_abort;
        chk("collision event", 1, o_evt_state[3]);
        {run, hold_low, i_slv_active, i_slv_drive_phase, i_slv_sda_val} = 5'h00;
        clr("collision");
        i_stat_w1s = 5'h01;
        tick;
        i_stat_w1s = 5'h00;
        i_stat_w1c = 5'h01;
        tick;
        i_stat_w1c = 5'h00;
        chk("clear before read", 6'h21, {o_irq, o_int_status});
        i_int_en = 5'h00;
        tick;
        chk("masked irq", 0, o_irq);
        i_int_en = 5'h1F;
        pulse(i_stat_rd);
        pulse(i_slv_xact_done);
        i_stat_w1c = 5'h1F;
        tick;
        i_stat_w1c = 5'h00;
        tick;
        chk("new event kept", 6'h28, {o_irq, o_int_status});
        clr("set and clear");
        i_stat_w1s = 5'h10;
        tick;
        i_stat_w1s = 5'h00;
        chk("set before reset", 6'h30, {o_irq, o_int_status});
        i_rst_n = 1'b0;
        repeat (2) tick;
        chk("reset in run", 0, {o_irq, o_int_status, o_evt_state});
        i_rst_n = 1'b1;
        tick;
        chk("after reset", 0, {o_irq, o_int_status, o_evt_state, o_bl_abort, o_slv_abort});
        $display("test reset in run done");
        give_verdict;
    end
endmodule
`default_nettype wire
